// File: hw/cdmp_ctrl.sv
// Crate controller top: APB register slave driving the dataway command cycle.
// Assumes APB master at i_mclk; dataway inputs already synchronous to i_mclk.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cdmp_ctrl
	import cdmp_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [cdmp_pkg::N_SLOTS-1:0] o_dw_n,
	output cdmp_pkg::cdmp_af_t o_dw_cmd,
	output logic [cdmp_pkg::DW_W-1:0] o_dw_w,
	output logic o_dw_s1,
	output logic o_dw_s2,
	output logic o_dw_b,
	output logic o_dw_z,
	output logic o_dw_c,
	output logic o_dw_i,
	input wire logic [cdmp_pkg::DW_W-1:0] i_dw_r,
	input wire logic i_dw_x,
	input wire logic i_dw_q,
	input wire logic [cdmp_pkg::N_SLOTS-1:0] i_dw_l
);
	import cdmp_pkg::*;

	logic [4:0] station_r;
	logic start_r;
	cdmp_kind_t kind_r;
	logic inh_req_r;
	logic [DW_W-1:0] rdata_r;
	logic x_r, q_r, done_r;
	logic [N_SLOTS-1:0] lam_r;
	logic cap, seq_done;
	logic acc, wr_take;

	// One-hot station line for slots 1..24; anything else selects nobody
	function automatic logic [N_SLOTS-1:0] station_line(input logic [4:0] n);
		logic [N_SLOTS-1:0] v;
		v = '0;
		if (n >= 5'h01 && n <= 5'h18) begin
			v[n - 5'h01] = 1'b1;
		end
		return v;
	endfunction : station_line

	function automatic logic reg_mapped(input logic [7:0] a);
		return a == REG_CTRL || a == REG_CMD || a == REG_WDATA ||
			a == REG_RDATA || a == REG_STATUS || a == REG_LAM;
	endfunction : reg_mapped

	assign acc = i_psel && i_penable;
	assign wr_take = acc && o_pready && i_pwrite && reg_mapped(i_paddr);

	cdmp_seq u_seq (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_start(start_r),
		.i_kind(kind_r),
		.i_station(station_line(station_r)),
		.o_busy(o_dw_b),
		.o_s1(o_dw_s1),
		.o_s2(o_dw_s2),
		.o_z(o_dw_z),
		.o_c(o_dw_c),
		.o_station(o_dw_n),
		.o_cap(cap),
		.o_done(seq_done)
	);

	// APB answer one cycle into the access phase
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h00000000;
		end else begin
			o_pready <= acc && !o_pready;
			if (acc && !o_pready) begin
				o_pslverr <= !reg_mapped(i_paddr);
				case (i_paddr)
					REG_CTRL: o_prdata <= {28'h0000000, inh_req_r, 3'h0};
					REG_CMD: o_prdata <= {11'h000, station_r, 4'h0, o_dw_cmd.sub,
						3'h0, o_dw_cmd.func};
					REG_WDATA: o_prdata <= {8'h00, o_dw_w};
					REG_RDATA: o_prdata <= {8'h00, rdata_r};
					REG_STATUS: o_prdata <= {28'h0000000, q_r, x_r, done_r, o_dw_b};
					REG_LAM: o_prdata <= {8'h00, lam_r};
					default: o_prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Command, address and write data held still while busy
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			station_r <= 5'h00;
			o_dw_cmd <= '0;
			o_dw_w <= DW_ZERO;
		end else if (wr_take && !o_dw_b && !start_r) begin
			if (i_paddr == REG_CMD) begin
				station_r <= i_pwdata[CMD_N_LSB +: 5];
				o_dw_cmd.sub <= i_pwdata[CMD_A_LSB +: 4];
				o_dw_cmd.func <= i_pwdata[CMD_F_LSB +: 5];
			end
			if (i_paddr == REG_WDATA) begin
				o_dw_w <= i_pwdata[DW_W-1:0];
			end
		end
	end

	// Cycle launch; initialize beats clear beats a plain command
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			start_r <= 1'b0;
			kind_r <= CDMP_KIND_CMD;
		end else begin
			start_r <= 1'b0;
			if (wr_take && i_paddr == REG_CTRL && !o_dw_b && !start_r) begin
				if (i_pwdata[CTRL_INIT_BIT]) begin
					start_r <= 1'b1;
					kind_r <= CDMP_KIND_INIT;
				end else if (i_pwdata[CTRL_CLEAR_BIT]) begin
					start_r <= 1'b1;
					kind_r <= CDMP_KIND_CLEAR;
				end else if (i_pwdata[CTRL_GO_BIT]) begin
					start_r <= 1'b1;
					kind_r <= CDMP_KIND_CMD;
				end
			end
		end
	end

	// Inhibit request reaches the line only outside busy
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			inh_req_r <= 1'b0;
			o_dw_i <= 1'b0;
		end else begin
			if (wr_take && i_paddr == REG_CTRL) begin
				inh_req_r <= i_pwdata[CTRL_INH_BIT];
			end
			if (!o_dw_b && !start_r) begin
				o_dw_i <= inh_req_r;
			end
		end
	end

	// Read data, accepted and response taken at the last S1 cycle
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rdata_r <= DW_ZERO;
			x_r <= 1'b0;
			q_r <= 1'b0;
		end else if (cap) begin
			x_r <= i_dw_x;
			q_r <= i_dw_q;
			if (o_dw_cmd.func[4:3] == F_GROUP_READ) begin
				rdata_r <= i_dw_r;
			end
		end
	end

	// Done is sticky; write one clears, a new completion wins
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			done_r <= 1'b0;
		end else if (seq_done) begin
			done_r <= 1'b1;
		end else if (wr_take && i_paddr == REG_STATUS && i_pwdata[ST_DONE_BIT]) begin
			done_r <= 1'b0;
		end
	end

	// Look-at-me only sampled while busy is absent
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			lam_r <= '0;
		end else if (!o_dw_b) begin
			lam_r <= i_dw_l;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	a_write_stable: assert property (o_dw_b && $past(o_dw_b) |-> $stable(o_dw_w))
		else $error("write lines changed during busy");
	a_addr_stable: assert property (o_dw_b && $past(o_dw_b) |-> $stable(o_dw_cmd))
		else $error("sub-address or function changed during busy");
	a_inhibit_still: assert property (o_dw_b && $past(o_dw_b) |-> $stable(o_dw_i))
		else $error("inhibit changed during busy");
	a_read_capture: assert property (cap && o_dw_cmd.func[4:3] == F_GROUP_READ && o_dw_s1
		|=> rdata_r == $past(i_dw_r) && x_r == $past(i_dw_x))
		else $error("read data not taken at S1");
	a_lam_gated: assert property (o_dw_b |=> $stable(lam_r))
		else $error("look-at-me sampled during busy");
	a_station_release: assert property ($fell(o_dw_b) |-> o_dw_n == '0 ##1 done_r)
		else $error("station held after busy or done not set");
	a_launch_busy: assert property (start_r |=> o_dw_b ##1 o_dw_b)
		else $error("start did not raise busy");
	c_read_cycle: cover property (cap && o_dw_cmd.func == 5'h00 ##[1:40] seq_done);
	c_write_cycle: cover property (cap && o_dw_cmd.func == 5'h10);
	c_lam_seen: cover property (!o_dw_b && |i_dw_l);
endmodule : cdmp_ctrl
`default_nettype wire

// File: hw/cdmp_seq.sv
// Dataway cycle sequencer: busy, strobes S1/S2, station and common controls.
// Assumes one start pulse per cycle, given only while idle.
`timescale 1ns/1ps
`default_nettype none
module cdmp_seq
	import cdmp_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire cdmp_pkg::cdmp_kind_t i_kind,
	input wire logic [cdmp_pkg::N_SLOTS-1:0] i_station,
	output logic o_busy,
	output logic o_s1,
	output logic o_s2,
	output logic o_z,
	output logic o_c,
	output logic [cdmp_pkg::N_SLOTS-1:0] o_station,
	output logic o_cap,
	output logic o_done
);
	typedef enum {SQ_IDLE, SQ_SETUP, SQ_S1, SQ_GAP, SQ_S2, SQ_TAIL} cdmp_seq_state_t;
	cdmp_seq_state_t state_r, state_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	cdmp_kind_t kind_r, kind_nxt;
	logic cmd_nxt;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r - 6'h01;
		kind_nxt = kind_r;
		case (state_r)
			SQ_IDLE: begin
				cnt_nxt = CYC_SETUP - 6'h01;
				if (i_start) begin
					state_nxt = SQ_SETUP;
					kind_nxt = i_kind;
				end
			end
			SQ_SETUP: if (cnt_r == 6'h00) begin
				state_nxt = SQ_S1;
				cnt_nxt = CYC_S1 - 6'h01;
			end
			SQ_S1: if (cnt_r == 6'h00) begin
				state_nxt = SQ_GAP;
				cnt_nxt = CYC_GAP - 6'h01;
			end
			SQ_GAP: if (cnt_r == 6'h00) begin
				state_nxt = SQ_S2;
				cnt_nxt = CYC_S2 - 6'h01;
			end
			SQ_S2: if (cnt_r == 6'h00) begin
				state_nxt = SQ_TAIL;
				cnt_nxt = CYC_TAIL - 6'h01;
			end
			SQ_TAIL: if (cnt_r == 6'h00) begin
				state_nxt = SQ_IDLE;
			end
			default: state_nxt = SQ_IDLE;
		endcase
		cmd_nxt = kind_nxt == CDMP_KIND_CMD;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_r <= SQ_IDLE;
			cnt_r <= 6'h00;
			kind_r <= CDMP_KIND_CMD;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			kind_r <= kind_nxt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_busy <= 1'b0;
			o_s1 <= 1'b0;
			o_s2 <= 1'b0;
			o_z <= 1'b0;
			o_c <= 1'b0;
			o_station <= '0;
			o_cap <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_busy <= state_nxt != SQ_IDLE;
			o_s1 <= state_nxt == SQ_S1 && cmd_nxt;
			o_s2 <= state_nxt == SQ_S2;
			o_z <= state_nxt == SQ_S2 && kind_nxt == CDMP_KIND_INIT;
			o_c <= state_nxt == SQ_S2 && kind_nxt == CDMP_KIND_CLEAR;
			o_station <= (state_nxt != SQ_IDLE && cmd_nxt) ? i_station : '0;
			o_cap <= state_nxt == SQ_S1 && cnt_nxt == 6'h00 && cmd_nxt;
			o_done <= state_r == SQ_TAIL && cnt_r == 6'h00;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	a_busy_length: assert property ($rose(o_busy) |-> ##47 o_busy ##1 !o_busy)
		else $error("busy length is not 48 cycles");
	a_strobe_order: assert property ($rose(o_s1) |-> o_s1[*8] ##1 !o_s1 ##8 $rose(o_s2))
		else $error("S2 does not follow S1 at the set spacing");
	a_init_with_s2: assert property (o_z |-> o_s2 && o_busy && !o_c)
		else $error("initialize without S2 and busy");
	a_clear_with_s2: assert property (o_c |-> o_s2 && o_busy)
		else $error("clear without S2 and busy");
	a_station_busy: assert property (|o_station |-> o_busy && !o_z && !o_c)
		else $error("station line without busy");
	c_init_cycle: cover property ($rose(o_z));
	c_clear_cycle: cover property ($rose(o_c));
endmodule : cdmp_seq
`default_nettype wire

// File: include/cdmp_pkg.sv
// Constants, types and helpers for the dataway crate controller.
// Assumes a 40 MHz system clock and a single 24-slot crate dataway.
// What this block does
// - Data moves up to 24 bits wide on separate read and write lines.
// - Controller drives write lines before S1 and holds them to the end.
// - Controller captures read-line data at strobe S1.
// - Busy is asserted during every cycle and whenever a station line is.
// - While busy is asserted, look-at-me is gated off the bus.
// - Initialize overrides everything and always comes with S2 and busy.
// - Clear resets connected registers and its issuer also makes S2 and busy.
// - Inhibit blocks activity and does not change while busy is present.
// - A whole single command cycle takes about 1.2 microseconds.
package cdmp_pkg;
	localparam int CLK_NS = 25;
	localparam int T_SETUP_NS = 400;
	localparam int T_S1_NS = 200;
	localparam int T_GAP_NS = 200;
	localparam int T_S2_NS = 200;
	localparam int T_TAIL_NS = 200;
	localparam int DW_W = 24;
	localparam int N_SLOTS = 24;

	// Least time in cycles, rounded up, never below one
	function automatic logic [5:0] ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		if (c < 1) begin
			c = 1;
		end
		return 6'(c);
	endfunction : ns_to_cyc

	localparam logic [5:0] CYC_SETUP = ns_to_cyc(T_SETUP_NS);
	localparam logic [5:0] CYC_S1 = ns_to_cyc(T_S1_NS);
	localparam logic [5:0] CYC_GAP = ns_to_cyc(T_GAP_NS);
	localparam logic [5:0] CYC_S2 = ns_to_cyc(T_S2_NS);
	localparam logic [5:0] CYC_TAIL = ns_to_cyc(T_TAIL_NS);

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_LAM = 8'h14;

	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_INIT_BIT = 1;
	localparam int CTRL_CLEAR_BIT = 2;
	localparam int CTRL_INH_BIT = 3;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_X_BIT = 2;
	localparam int ST_Q_BIT = 3;
	localparam int CMD_F_LSB = 0;
	localparam int CMD_A_LSB = 8;
	localparam int CMD_N_LSB = 16;

	localparam logic [1:0] F_GROUP_READ = 2'h0;
	localparam logic [DW_W-1:0] DW_ZERO = 24'h000000;

	typedef enum logic [1:0] {
		CDMP_KIND_CMD,
		CDMP_KIND_INIT,
		CDMP_KIND_CLEAR
	} cdmp_kind_t;

	typedef struct packed {
		logic [3:0] sub;
		logic [4:0] func;
	} cdmp_af_t;
endpackage : cdmp_pkg

// File: tb/cdmp_ctrl_tb.sv
// Self-checking bench for the dataway controller: APB tasks, one module model, bus monitor.
// Assumes the model sits in slot SLOT and every other slot is empty.
`timescale 1ns/1ps
`default_nettype none
module cdmp_ctrl_tb;
	import cdmp_pkg::*;
	localparam int SLOT = 5;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, s1, s2, b, z, c, io, x, q, l;
	logic [N_SLOTS-1:0] dw_n;
	cdmp_af_t dw_cmd;
	logic [DW_W-1:0] dw_w, dw_r, wprev;
	logic iprev;
	logic [23:0] g1 [16];
	logic [23:0] g2 [16];
	logic lam = 1'b0;
	logic en = 1'b1;
	logic inh = 1'b0;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;
	int bcnt = 0;
	initial forever #12.5 i_mclk = ~i_mclk;
	cdmp_ctrl dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_dw_n(dw_n), .o_dw_cmd(dw_cmd),
		.o_dw_w(dw_w), .o_dw_s1(s1), .o_dw_s2(s2), .o_dw_b(b), .o_dw_z(z), .o_dw_c(c),
		.o_dw_i(io), .i_dw_r(dw_r), .i_dw_x(x), .i_dw_q(q), .i_dw_l(24'(l) << (SLOT - 1)));
	cdmp_mod_model #(.SLOT(SLOT)) model (.i_mclk(i_mclk), .i_n(dw_n), .i_cmd(dw_cmd),
		.i_w(dw_w), .i_s1(s1), .i_s2(s2), .i_b(b), .i_z(z), .i_c(c), .i_i(io),
		.o_r(dw_r), .o_x(x), .o_q(q), .o_l(l));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		pwr <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge i_mclk);
		pen <= 1'b1;
		// Ends on pready; only the bench timeout ends a stuck wait
		do begin
			@(posedge i_mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// One idle edge so the next call never reassigns psel in this step
		@(posedge i_mclk);
	endtask : apb
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		logic [31:0] d;
		logic e;
		apb(1'b1, ad, wd, d, e);
	endtask : wr
	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		logic e;
		apb(1'b0, ad, 32'h0, d, e);
	endtask : rd
	task automatic wait_done(output logic [31:0] d);
		int t;
		t = 0;
		do begin
			rd(REG_STATUS, d);
			if (t == 0) chk("busy", 32'(d[ST_BUSY_BIT]), 32'h1);
			t++;
		end while (d[ST_DONE_BIT] !== 1'b1);
		wr(REG_STATUS, 32'h2);
	endtask : wait_done
	task automatic chk_lam;
		logic [31:0] d;
		rd(REG_LAM, d);
		chk("lam", d, 32'(lam) << (SLOT - 1));
	endtask : chk_lam
	task automatic run(input logic [4:0] n, input logic [3:0] a, input logic [4:0] f,
		input logic [23:0] w);
		logic [31:0] d;
		logic ex, eq;
		logic [23:0] er;
		ex = n == SLOT && !(f inside {[4:7], [12:15], 20, 22, [28:31]});
		er = f == 1 ? g2[a] : (f == 3 ? ~g1[a] : g1[a]);
		eq = ex && (f == 8 ? lam : (f == 27 ? en : 1'b1));
		wr(REG_WDATA, {8'h00, w});
		wr(REG_CMD, {11'h000, n, 4'h0, a, 3'h0, f});
		rd(REG_CMD, d);
		chk("cmd", d, {11'h000, n, 4'h0, a, 3'h0, f});
		wr(REG_CTRL, {28'h0000000, inh, 3'h1});
		wait_done(d);
		chk("x", 32'(d[ST_X_BIT]), 32'(ex));
		chk("q", 32'(d[ST_Q_BIT]), 32'(eq));
		if (ex && f < 4) begin
			rd(REG_RDATA, d);
			chk("rdata", d, {8'h00, er});
		end
		if (ex) begin
			case (f)
				2, 9: g1[a] = 24'h000000;
				10: lam = 1'b0;
				11: g2[a] = 24'h000000;
				16: g1[a] = w;
				17: g2[a] = w;
				18: g1[a] = g1[a] | w;
				19: g2[a] = g2[a] | w;
				21: g1[a] = g1[a] & ~w;
				23: g2[a] = g2[a] & ~w;
				24: en = 1'b0;
				25: lam = lam || (en && !inh);
				26: en = 1'b1;
				default: ;
			endcase
		end
		chk_lam();
	endtask : run
	task automatic cc(input logic [31:0] bits);
		logic [31:0] d;
		wr(REG_CTRL, bits | {28'h0000000, inh, 3'h0});
		wait_done(d);
		g1 = '{default: 24'h000000};
		g2 = '{default: 24'h000000};
		lam = lam && !bits[CTRL_INIT_BIT];
		en = en || bits[CTRL_INIT_BIT];
		chk_lam();
	endtask : cc
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			print_verdict();
		end
		wprev <= dw_w;
		iprev <= io;
		bcnt <= b ? bcnt + 1 : 0;
		if (!i_rst) begin
			if (b && bcnt != 0 && (dw_w !== wprev || io !== iprev)) chk("w_i_held", 0, 1);
			if (!b && bcnt != 0) chk("busy_len", bcnt, 48);
			if (|dw_n && b !== 1'b1) chk("busy_n", 0, 1);
			if ((z || c) && !(s2 && b)) chk("zc_s2", 0, 1);
		end
	end
	initial begin
		logic [31:0] d;
		logic e;
		void'($urandom(73822));
		g1 = '{default: 24'h000000};
		g2 = '{default: 24'h000000};
		repeat (6) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		apb(1'b0, 8'h20, 32'h0, d, e);
		chk("unmapped", {d[30:0], e}, 32'h1);
		for (int f = 0; f < 32; f++) begin
			run(5'(SLOT), 4'(f), 5'(f), 24'($urandom));
		end
		inh = 1'b1;
		wr(REG_CTRL, 32'h8);
		run(5'(SLOT), 4'h3, 5'h19, 24'h0);
		inh = 1'b0;
		wr(REG_CTRL, 32'h0);
		run(5'(SLOT), 4'h3, 5'h19, 24'h0);
		run(5'(SLOT), 4'h0, 5'h08, 24'h0);
		run(5'(SLOT), 4'h0, 5'h0a, 24'h0);
		run(5'h00, 4'h1, 5'h10, 24'hffffff);
		run(5'd25, 4'h1, 5'h10, 24'hffffff);
		run(5'(SLOT + 1), 4'h1, 5'h10, 24'hffffff);
		run(5'(SLOT), 4'h1, 5'h00, 24'h0);
		run(5'(SLOT), 4'h2, 5'h10, 24'ha5a5a5);
		cc(32'h4);
		run(5'(SLOT), 4'h2, 5'h00, 24'h0);
		run(5'(SLOT), 4'h2, 5'h11, 24'h5a5a5a);
		run(5'(SLOT), 4'h0, 5'h19, 24'h0);
		cc(32'h2);
		run(5'(SLOT), 4'h2, 5'h01, 24'h0);
		repeat (50) begin
			run($urandom_range(3) == 0 ? 5'($urandom) : 5'(SLOT), 4'($urandom),
				5'($urandom), 24'($urandom));
		end
		print_verdict();
	end
endmodule : cdmp_ctrl_tb
`default_nettype wire

// File: tb/cdmp_mod_model.sv
// Behavioural dataway module in one slot: two groups of 16 sections, lam, enable.
// Assumes controller outputs registered on i_mclk; released X/Q lines terminate low.
`timescale 1ns/1ps
`default_nettype none
module cdmp_mod_model
	import cdmp_pkg::*;
#(
	parameter int SLOT = 5
) (
	input wire logic i_mclk,
	input wire logic [cdmp_pkg::N_SLOTS-1:0] i_n,
	input wire cdmp_pkg::cdmp_af_t i_cmd,
	input wire logic [cdmp_pkg::DW_W-1:0] i_w,
	input wire logic i_s1,
	input wire logic i_s2,
	input wire logic i_b,
	input wire logic i_z,
	input wire logic i_c,
	input wire logic i_i,
	output logic [cdmp_pkg::DW_W-1:0] o_r,
	output logic o_x,
	output logic o_q,
	output logic o_l
);
	logic [DW_W-1:0] g1_r [16];
	logic [DW_W-1:0] g2_r [16];
	logic lam_r = 1'b0;
	logic en_r = 1'b1;
	logic s1_d = 1'b0;
	logic s2_d = 1'b0;
	logic sel, kn, s1e, s2e;
	logic [4:0] f;
	logic [3:0] a;
	assign sel = i_n[SLOT-1];
	assign f = i_cmd.func;
	assign a = i_cmd.sub;
	assign kn = !(f inside {[5'h04:5'h07], [5'h0c:5'h0f], 5'h14, 5'h16, [5'h1c:5'h1f]});
	assign s1e = i_s1 && !s1_d;
	assign s2e = i_s2 && !s2_d;
	assign o_l = lam_r && !i_b;
	initial begin
		g1_r = '{default: 24'h000000};
		g2_r = '{default: 24'h000000};
		{o_r, o_x, o_q} = 26'h0;
	end
	always @(posedge i_mclk) begin
		s1_d <= i_s1;
		s2_d <= i_s2;
		if (s2e && i_z) begin
			g1_r <= '{default: 24'h000000};
			g2_r <= '{default: 24'h000000};
			lam_r <= 1'b0;
			en_r <= 1'b1;
		end else if (s2e && i_c) begin
			g1_r <= '{default: 24'h000000};
			g2_r <= '{default: 24'h000000};
		end else if (sel && s1e) begin
			case (f)
				5'h10: g1_r[a] <= i_w;
				5'h11: g2_r[a] <= i_w;
				5'h12: g1_r[a] <= g1_r[a] | i_w;
				5'h13: g2_r[a] <= g2_r[a] | i_w;
				5'h15: g1_r[a] <= g1_r[a] & ~i_w;
				5'h17: g2_r[a] <= g2_r[a] & ~i_w;
				default: ;
			endcase
		end else if (sel && s2e) begin
			case (f)
				5'h02, 5'h09: g1_r[a] <= 24'h000000;
				5'h0a: lam_r <= 1'b0;
				5'h0b: g2_r[a] <= 24'h000000;
				5'h18: en_r <= 1'b0;
				5'h1a: en_r <= 1'b1;
				5'h19: lam_r <= lam_r || (en_r && !i_i);
				default: ;
			endcase
		end
		o_x <= sel && kn;
		o_q <= sel && kn && (f == 5'h08 ? lam_r : (f == 5'h1b ? en_r : 1'b1));
		if (sel && f < 5'h04) begin
			o_r <= f == 5'h01 ? g2_r[a] : (f == 5'h03 ? ~g1_r[a] : g1_r[a]);
		end else begin
			o_r <= ~o_r;
		end
	end
endmodule : cdmp_mod_model
`default_nettype wire
